//--- rtl/rfa_pkg.sv
package rfa_pkg;
    localparam int RFA_W = 16;
    localparam int RFA_AW = 2;

    // Field access kinds, one code per bit position
    typedef enum logic [3:0] {
        RFA_IGN_K = 4'h0,
        RFA_MBZ_K = 4'h1,
        RFA_RAO_K = 4'h2,
        RFA_RAZ_K = 4'h3,
        RFA_RC_K = 4'h4,
        RFA_RSV_K = 4'h5,
        RFA_RO_K = 4'h6,
        RFA_RW_K = 4'h7,
        RFA_W0C_K = 4'h8,
        RFA_W1C_K = 4'h9,
        RFA_WO_K = 4'hA
    } rfa_kind_t;

    localparam logic [RFA_W-1:0] RFA_ZERO = 16'h0000;
    localparam logic [RFA_W-1:0] RFA_ONES = 16'hFFFF;

    // Software access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [RFA_W-1:0] wdata;
    } rfa_req_t;

    // Hardware status update
    typedef struct packed {
        logic load;
        logic [RFA_W-1:0] data;
    } rfa_hw_t;

    // Answer to software
    typedef struct packed {
        logic ack;
        logic [RFA_W-1:0] rdata;
    } rfa_rsp_t;

    typedef struct packed {
        logic [RFA_W-1:0] store;
        logic [RFA_W-1:0] full;
        rfa_rsp_t rsp;
    } rfa_state_t;
endpackage : rfa_pkg

//--- rtl/rfa_field_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - Ignored bits discard writes, no state change
// - Read-as-one bits always read one
// - Read-as-zero bits always read zero
// - Read-clear holds capture until software reads
// - Read-only bits read value, ignore writes
// - Read/write bits store and return writes
// - Writing zero clears write-zero-clear bits, unless hardware sets them in the same cycle
// - Writing one clears write-one-clear bits, unless hardware sets them in the same cycle
// - Write-only bits accept writes, hide value
module rfa_field_bank
    import rfa_pkg::*;
#(
    parameter rfa_kind_t KIND [rfa_pkg::RFA_W] = '{default: RFA_RW_K}
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Software side
    input rfa_pkg::rfa_req_t sw_req,
    output rfa_pkg::rfa_rsp_t sw_rsp,
    // Hardware side
    input rfa_pkg::rfa_hw_t hw_upd,
    output logic [rfa_pkg::RFA_W-1:0] field_q
);
    import rfa_pkg::*;

    rfa_state_t state_reg;
    rfa_state_t state_next;

    // Read value of one bit by its kind
    function automatic logic rd_bit(input rfa_kind_t k, input logic v);
        case (k)
            RFA_RAO_K: rd_bit = 1'b1;
            RFA_RC_K, RFA_RO_K, RFA_RW_K,
            RFA_W0C_K, RFA_W1C_K: rd_bit = v;
            default: rd_bit = 1'b0;
        endcase
    endfunction : rd_bit

    always_comb begin
        state_next = state_reg;
        state_next.rsp.ack = sw_req.rd | sw_req.wr;
        for (int i = 0; i < RFA_W; i++) begin
            state_next.rsp.rdata[i] = sw_req.rd ?
                rd_bit(KIND[i], state_reg.store[i]) : 1'b0;
            case (KIND[i])
                RFA_RW_K, RFA_WO_K: begin
                    if (sw_req.wr) begin
                        state_next.store[i] = sw_req.wdata[i];
                    end
                end
                RFA_RO_K: begin
                    if (hw_upd.load) begin
                        state_next.store[i] = hw_upd.data[i];
                    end
                end
                RFA_RC_K: begin
                    if (sw_req.rd) begin
                        state_next.full[i] = 1'b0;
                    end
                    if (hw_upd.load && (!state_reg.full[i] || sw_req.rd)) begin
                        state_next.store[i] = hw_upd.data[i];
                        state_next.full[i] = 1'b1;
                    end
                end
                RFA_W0C_K: begin
                    if (sw_req.wr && !sw_req.wdata[i]) begin
                        state_next.store[i] = 1'b0;
                    end
                    if (hw_upd.load && hw_upd.data[i]) begin
                        state_next.store[i] = 1'b1;
                    end
                end
                RFA_W1C_K: begin
                    if (sw_req.wr && sw_req.wdata[i]) begin
                        state_next.store[i] = 1'b0;
                    end
                    if (hw_upd.load && hw_upd.data[i]) begin
                        state_next.store[i] = 1'b1;
                    end
                end
                default: begin
                    state_next.store[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sw_rsp = state_reg.rsp;
    assign field_q = state_reg.store;

    sequence s_access;
        sw_req.rd || sw_req.wr;
    endsequence

    property p_ack;
        @(posedge clk_sys) disable iff (sys_rst)
        s_access |=> sw_rsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");

    for (genvar g = 0; g < RFA_W; g++) begin : g_chk
        if (KIND[g] == RFA_RAO_K) begin : g_rao
            property p_rao;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.rd |=> sw_rsp.rdata[g];
            endproperty
            a_rao: assert property (p_rao) else $error("rao bit");
        end
        if (KIND[g] == RFA_RAZ_K || KIND[g] == RFA_WO_K ||
            KIND[g] == RFA_IGN_K) begin : g_raz
            property p_raz;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.rd |=> !sw_rsp.rdata[g];
            endproperty
            a_raz: assert property (p_raz) else $error("zero bit");
        end
        if (KIND[g] == RFA_RW_K) begin : g_rw
            property p_rw;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.wr ##1 sw_req.rd && !sw_req.wr
                    |=> sw_rsp.rdata[g] == $past(sw_req.wdata[g], 2);
            endproperty
            a_rw: assert property (p_rw) else $error("rw bit");
        end
        if (KIND[g] == RFA_RO_K) begin : g_ro
            property p_ro;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.wr && !hw_upd.load |=> $stable(field_q[g]);
            endproperty
            a_ro: assert property (p_ro) else $error("ro bit");
        end
        if (KIND[g] == RFA_RC_K) begin : g_rc
            property p_rc;
                @(posedge clk_sys) disable iff (sys_rst)
                state_reg.full[g] && !sw_req.rd |=> $stable(field_q[g]);
            endproperty
            a_rc: assert property (p_rc) else $error("rc held");
        end
        if (KIND[g] == RFA_W1C_K) begin : g_w1c
            property p_w1c;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.wr && sw_req.wdata[g] && !hw_upd.load
                    |=> !field_q[g];
            endproperty
            a_w1c: assert property (p_w1c) else $error("w1c");
            property p_set;
                @(posedge clk_sys) disable iff (sys_rst)
                hw_upd.load && hw_upd.data[g] |=> field_q[g];
            endproperty
            a_set: assert property (p_set) else $error("set win");
        end
        if (KIND[g] == RFA_W0C_K) begin : g_w0c
            property p_w0c;
                @(posedge clk_sys) disable iff (sys_rst)
                sw_req.wr && !sw_req.wdata[g] && !hw_upd.load
                    |=> !field_q[g];
            endproperty
            a_w0c: assert property (p_w0c) else $error("w0c");
        end
        if (KIND[g] == RFA_IGN_K) begin : g_ign
            property p_ign;
                @(posedge clk_sys) disable iff (sys_rst)
                1'b1 |=> !field_q[g];
            endproperty
            a_ign: assert property (p_ign) else $error("ign");
        end
    end
endmodule : rfa_field_bank

//--- bench/rfa_field_bank_test.sv
`timescale 1ns/1ps
module rfa_field_bank_test;
    import rfa_pkg::*;
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    $display("mismatch %s exp %h got %h", nm, ex, got); \
    mismatches++; end end
    localparam rfa_kind_t KT [RFA_W] = '{RFA_IGN_K, RFA_MBZ_K, RFA_RAO_K,
        RFA_RAZ_K, RFA_RC_K, RFA_RSV_K, RFA_RO_K, RFA_RW_K, RFA_W0C_K,
        RFA_W1C_K, RFA_WO_K, RFA_RC_K, RFA_RW_K, RFA_W1C_K, RFA_W0C_K,
        RFA_RO_K};
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    rfa_req_t sw_req = '0;
    rfa_rsp_t sw_rsp;
    rfa_hw_t hw_upd = '0;
    logic [RFA_W-1:0] field_q;
    logic [RFA_W-1:0] st = '0;
    logic [RFA_W-1:0] full = '0;
    logic [2*RFA_W-1:0] notes [$];
    logic [2*RFA_W-1:0] note;
    logic [1:0] op;
    int mismatches = 0;
    int n_checks = 0;

    always #20 clk_sys = ~clk_sys;

    rfa_field_bank #(.KIND(KT)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .sw_req(sw_req), .sw_rsp(sw_rsp), .hw_upd(hw_upd), .field_q(field_q));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // Reference of the bits, applied to the request taken at this edge
    task automatic model();
        logic [RFA_W-1:0] rv;
        logic [RFA_W-1:0] km;
        rv = RFA_ZERO;
        km = RFA_ONES;
        for (int i = 0; i < RFA_W; i++) begin
            case (KT[i])
                RFA_RAO_K: rv[i] = 1'b1;
                RFA_RW_K, RFA_RO_K, RFA_W0C_K, RFA_W1C_K: rv[i] = st[i];
                RFA_RC_K: {rv[i], km[i]} = {st[i], full[i]};
                default: rv[i] = 1'b0;
            endcase
            case (KT[i])
                RFA_RW_K, RFA_WO_K: if (sw_req.wr) st[i] = sw_req.wdata[i];
                RFA_RO_K: if (hw_upd.load) st[i] = hw_upd.data[i];
                RFA_RC_K: if (hw_upd.load && (!full[i] || sw_req.rd)) begin
                    {st[i], full[i]} = {hw_upd.data[i], 1'b1};
                end else if (sw_req.rd) full[i] = 1'b0;
                RFA_W0C_K: if (hw_upd.load && hw_upd.data[i]) st[i] = 1'b1;
                    else if (sw_req.wr && !sw_req.wdata[i]) st[i] = 1'b0;
                RFA_W1C_K: if (hw_upd.load && hw_upd.data[i]) st[i] = 1'b1;
                    else if (sw_req.wr && sw_req.wdata[i]) st[i] = 1'b0;
                default: st[i] = 1'b0;
            endcase
        end
        if (sw_req.rd) notes.push_back({rv, km});
        else if (sw_req.wr) notes.push_back({RFA_ZERO, RFA_ONES});
    endtask : model

    // Answer watcher
    always @(negedge clk_sys) begin
        if (notes.size() == 0) begin
            `CHK("ack", 1'b0, sw_rsp.ack)
        end else begin
            note = notes.pop_front();
            `CHK("ack", 1'b1, sw_rsp.ack)
            `CHK("rdata", note[31:16] & note[15:0], sw_rsp.rdata & note[15:0])
        end
    end

    // Random traffic
    initial begin
        void'($urandom(32'hC1D8981F));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (600) begin
            @(posedge clk_sys);
            model();
            op = 2'($urandom);
            sw_req <= '{wr: op == 2'h2, rd: op[0],
                wdata: 16'($urandom) & 16'hFFDD};
            hw_upd <= '{load: 2'($urandom) == 2'h0, data: 16'($urandom)};
        end
        @(posedge clk_sys);
        model();
        sw_req <= '0;
        hw_upd <= '0;
        repeat (3) @(posedge clk_sys);
        `CHK("pending", 0, notes.size())
        results();
    end

    // Watchdog
    initial begin
        repeat (2000) @(posedge clk_sys);
        mismatches++;
        results();
    end
endmodule : rfa_field_bank_test
